// [slmi_pkg.sv]
package slmi_pkg;

  // ********************************************************
  // dimensions
  // ********************************************************
  localparam int NUM_LANES = 8;
  localparam int SEL_W = 3;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;

  typedef logic [SEL_W-1:0] slmi_sel_t;
  typedef logic [ADDR_W-1:0] slmi_addr_t;
  typedef logic [DATA_W-1:0] slmi_data_t;

  // ********************************************************
  // register offsets
  // ********************************************************
  localparam slmi_addr_t MAP_ZERO_ONE_ADDR = 15'h05B2;
  localparam slmi_addr_t MAP_TWO_THREE_ADDR = 15'h05B3;
  localparam slmi_addr_t MAP_FOUR_FIVE_ADDR = 15'h05B5;
  localparam slmi_addr_t MAP_SIX_SEVEN_ADDR = 15'h05B6;
  localparam slmi_addr_t POLARITY_INVERT_ADDR = 15'h05BF;

  // ********************************************************
  // field positions inside a lane map register
  // ********************************************************
  localparam int EVEN_SEL_LSB = 0;
  localparam int ODD_SEL_LSB = 4;
  localparam int EVEN_RSVD_BIT = 3;
  localparam int ODD_RSVD_BIT = 7;

  // ********************************************************
  // reset values and the lane map write mask
  // ********************************************************
  localparam slmi_data_t MAP_ZERO_ONE_RST = 8'h10;
  localparam slmi_data_t MAP_TWO_THREE_RST = 8'h32;
  localparam slmi_data_t MAP_FOUR_FIVE_RST = 8'h54;
  localparam slmi_data_t MAP_SIX_SEVEN_RST = 8'h76;
  localparam slmi_data_t POLARITY_INVERT_RST = 8'h00;
  localparam slmi_data_t MAP_WRITE_MASK = 8'h77;

  // ********************************************************
  // register access request from the serial control port
  // ********************************************************
  typedef struct packed {
    slmi_addr_t addr;
    slmi_data_t wdata;
    logic wr;
    logic rd;
  } slmi_req_s;

endpackage : slmi_pkg

// [slmi_lane_xbar.sv]
`timescale 1ns/1ps
module slmi_lane_xbar #(
  parameter int LANE_W = 1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [slmi_pkg::NUM_LANES*slmi_pkg::SEL_W-1:0] sel,
  input wire logic [slmi_pkg::NUM_LANES-1:0] invert,
  input wire logic [slmi_pkg::NUM_LANES*LANE_W-1:0] logical_lane,
  output logic [slmi_pkg::NUM_LANES*LANE_W-1:0] serial_output_lane
);

  logic [slmi_pkg::NUM_LANES*LANE_W-1:0] lane_d;
  logic [slmi_pkg::NUM_LANES*LANE_W-1:0] lane_q;
  slmi_pkg::slmi_sel_t idx;

  // ********************************************************
  // crossbar and polarity
  // ********************************************************
  always_comb begin
    lane_d = '0;
    idx = '0;
    for (int p = 0; p < slmi_pkg::NUM_LANES; p++) begin
      idx = sel[p*slmi_pkg::SEL_W +: slmi_pkg::SEL_W];
      // plain binary index picks the logical lane
      lane_d[p*LANE_W +: LANE_W] = logical_lane[idx*LANE_W +: LANE_W]
                                   ^ {LANE_W{invert[p]}};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lane_q <= '0;
    end else begin
      lane_q <= lane_d;
    end
  end

  assign serial_output_lane = lane_q;

endmodule : slmi_lane_xbar

// [slmi_lane_map_invert.sv]
`timescale 1ns/1ps
module slmi_lane_map_invert #(
  parameter int LANE_W = 1
) (
  input wire logic core_clk,
  input wire logic reset,
  input slmi_pkg::slmi_req_s reg_req,
  output slmi_pkg::slmi_data_t reg_rdata,
  output logic reg_rvalid,
  input wire logic [slmi_pkg::NUM_LANES*LANE_W-1:0] logical_lane,
  output logic [slmi_pkg::NUM_LANES*LANE_W-1:0] serial_output_lane,
  output logic [slmi_pkg::NUM_LANES*slmi_pkg::SEL_W-1:0] lane_sel
);

  // ********************************************************
  // register state
  // ********************************************************
  slmi_pkg::slmi_data_t map01_q, map01_d;
  slmi_pkg::slmi_data_t map23_q, map23_d;
  slmi_pkg::slmi_data_t map45_q, map45_d;
  slmi_pkg::slmi_data_t map67_q, map67_d;
  slmi_pkg::slmi_data_t inv_q, inv_d;
  slmi_pkg::slmi_data_t rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  // ********************************************************
  // helpers
  // ********************************************************
  function automatic slmi_pkg::slmi_data_t map_write(input slmi_pkg::slmi_data_t wd);
    // reserved bits never store
    map_write = wd & slmi_pkg::MAP_WRITE_MASK;
  endfunction : map_write

  // a write strobe wins over a read strobe in the same cycle
  function automatic logic write_hit(
    input slmi_pkg::slmi_req_s req,
    input slmi_pkg::slmi_addr_t addr
  );
    write_hit = req.wr && (req.addr == addr);
  endfunction : write_hit

  function automatic slmi_pkg::slmi_sel_t even_sel(input slmi_pkg::slmi_data_t r);
    even_sel = r[slmi_pkg::EVEN_SEL_LSB +: slmi_pkg::SEL_W];
  endfunction : even_sel

  function automatic slmi_pkg::slmi_sel_t odd_sel(input slmi_pkg::slmi_data_t r);
    odd_sel = r[slmi_pkg::ODD_SEL_LSB +: slmi_pkg::SEL_W];
  endfunction : odd_sel

  function automatic slmi_pkg::slmi_data_t read_mux(
    input slmi_pkg::slmi_addr_t addr,
    input slmi_pkg::slmi_data_t m01,
    input slmi_pkg::slmi_data_t m23,
    input slmi_pkg::slmi_data_t m45,
    input slmi_pkg::slmi_data_t m67,
    input slmi_pkg::slmi_data_t inv
  );
    case (addr)
      slmi_pkg::MAP_ZERO_ONE_ADDR: read_mux = m01;
      slmi_pkg::MAP_TWO_THREE_ADDR: read_mux = m23;
      slmi_pkg::MAP_FOUR_FIVE_ADDR: read_mux = m45;
      slmi_pkg::MAP_SIX_SEVEN_ADDR: read_mux = m67;
      slmi_pkg::POLARITY_INVERT_ADDR: read_mux = inv;
      // unmapped offsets read as zero
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // ********************************************************
  // lane map, physical lanes 0 and 1
  // ********************************************************
  always_comb begin
    map01_d = map01_q;
    if (write_hit(reg_req, slmi_pkg::MAP_ZERO_ONE_ADDR)) begin
      map01_d = map_write(reg_req.wdata);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      map01_q <= slmi_pkg::MAP_ZERO_ONE_RST;
    end else begin
      map01_q <= map01_d;
    end
  end

  // ********************************************************
  // lane map, physical lanes 2 and 3
  // ********************************************************
  always_comb begin
    map23_d = map23_q;
    if (write_hit(reg_req, slmi_pkg::MAP_TWO_THREE_ADDR)) begin
      map23_d = map_write(reg_req.wdata);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      map23_q <= slmi_pkg::MAP_TWO_THREE_RST;
    end else begin
      map23_q <= map23_d;
    end
  end

  // ********************************************************
  // lane map, physical lanes 4 and 5
  // ********************************************************
  always_comb begin
    map45_d = map45_q;
    if (write_hit(reg_req, slmi_pkg::MAP_FOUR_FIVE_ADDR)) begin
      map45_d = map_write(reg_req.wdata);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      map45_q <= slmi_pkg::MAP_FOUR_FIVE_RST;
    end else begin
      map45_q <= map45_d;
    end
  end

  // ********************************************************
  // lane map, physical lanes 6 and 7
  // ********************************************************
  always_comb begin
    map67_d = map67_q;
    if (write_hit(reg_req, slmi_pkg::MAP_SIX_SEVEN_ADDR)) begin
      map67_d = map_write(reg_req.wdata);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      map67_q <= slmi_pkg::MAP_SIX_SEVEN_RST;
    end else begin
      map67_q <= map67_d;
    end
  end

  // ********************************************************
  // polarity, one bit per physical lane
  // ********************************************************
  always_comb begin
    inv_d = inv_q;
    if (write_hit(reg_req, slmi_pkg::POLARITY_INVERT_ADDR)) begin
      inv_d = reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      inv_q <= slmi_pkg::POLARITY_INVERT_RST;
    end else begin
      inv_q <= inv_d;
    end
  end

  // ********************************************************
  // read response, one cycle after the read strobe
  // ********************************************************
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = 1'h0;
    if (reg_req.rd && !reg_req.wr) begin
      rvalid_d = 1'h1;
      rdata_d = read_mux(reg_req.addr, map01_q, map23_q, map45_q, map67_q, inv_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'h0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ********************************************************
  // register port outputs
  // ********************************************************
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  // ********************************************************
  // selector bus, physical lane p at bits 3p+2 down to 3p
  // ********************************************************
  always_comb begin
    lane_sel = '0;
    lane_sel[0*slmi_pkg::SEL_W +: slmi_pkg::SEL_W] = even_sel(map01_q);
    lane_sel[1*slmi_pkg::SEL_W +: slmi_pkg::SEL_W] = odd_sel(map01_q);
    lane_sel[2*slmi_pkg::SEL_W +: slmi_pkg::SEL_W] = even_sel(map23_q);
    lane_sel[3*slmi_pkg::SEL_W +: slmi_pkg::SEL_W] = odd_sel(map23_q);
    lane_sel[4*slmi_pkg::SEL_W +: slmi_pkg::SEL_W] = even_sel(map45_q);
    lane_sel[5*slmi_pkg::SEL_W +: slmi_pkg::SEL_W] = odd_sel(map45_q);
    lane_sel[6*slmi_pkg::SEL_W +: slmi_pkg::SEL_W] = even_sel(map67_q);
    lane_sel[7*slmi_pkg::SEL_W +: slmi_pkg::SEL_W] = odd_sel(map67_q);
  end

  // ********************************************************
  // lane steering
  // ********************************************************
  slmi_lane_xbar #(
    .LANE_W(LANE_W)
  ) u_xbar (
    .core_clk(core_clk),
    .reset(reset),
    .sel(lane_sel),
    .invert(inv_q),
    .logical_lane(logical_lane),
    .serial_output_lane(serial_output_lane)
  );

endmodule : slmi_lane_map_invert

// [slmi_lane_rx.sv]
`timescale 1ns/1ps
module slmi_lane_rx (
  input wire logic core_clk,
  input wire logic [7:0] serial_output_lane,
  output logic [7:0] rx_q
);
  always_ff @(posedge core_clk) rx_q <= serial_output_lane;
endmodule : slmi_lane_rx

// [slmi_lane_map_invert_properties.sv]
`timescale 1ns/1ps
module slmi_lane_map_invert_properties #(
  parameter int LANE_W = 1
) (
  input wire logic core_clk,
  input wire logic reset,
  input slmi_pkg::slmi_req_s reg_req,
  input slmi_pkg::slmi_data_t reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [slmi_pkg::NUM_LANES*LANE_W-1:0] logical_lane,
  input wire logic [slmi_pkg::NUM_LANES*LANE_W-1:0] serial_output_lane,
  input wire logic [slmi_pkg::NUM_LANES*slmi_pkg::SEL_W-1:0] lane_sel
);
  logic [7:0] pol_q;
  always_ff @(posedge core_clk)
    if (reset) pol_q <= 8'h00;
    else if (reg_req.wr && reg_req.addr == 15'h05BF) pol_q <= reg_req.wdata;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_sel_reset: assert property ($fell(reset) |-> lane_sel == 24'hFAC688)
    else $error("selector reset value wrong");
  a_read_pulse: assert property (reg_req.rd && !reg_req.wr |=> reg_rvalid)
    else $error("read not answered");
  a_pulse_cause: assert property (reg_rvalid |-> $past(reg_req.rd && !reg_req.wr))
    else $error("stray read valid");
  a_rsvd_zero: assert property (reg_rvalid && $past(reg_req.addr) != 15'h05BF |->
    (reg_rdata & 8'h88) == 8'h00) else $error("reserved bit set");
  a_map_write: assert property (reg_req.wr && reg_req.addr == 15'h05B6 |=>
    lane_sel[23:18] == {$past(reg_req.wdata[6:4]), $past(reg_req.wdata[2:0])})
    else $error("selector write lost");
  a_sel_hold: assert property (!reg_req.wr |=> $stable(lane_sel))
    else $error("selector moved");
  for (genvar p = 0; p < 8; p++) begin : g_lane
    a_lane_route: assert property (!$past(reset) |->
      serial_output_lane[p*LANE_W +: LANE_W] ==
      $past(logical_lane[lane_sel[3*p +: 3]*LANE_W +: LANE_W] ^ {LANE_W{pol_q[p]}}))
      else $error("lane data wrong");
  end
endmodule : slmi_lane_map_invert_properties
bind slmi_lane_map_invert slmi_lane_map_invert_properties #(.LANE_W(LANE_W)) u_props (
  .core_clk, .reset, .reg_req, .reg_rdata, .reg_rvalid, .logical_lane, .serial_output_lane,
  .lane_sel);

// [slmi_lane_map_invert_test.sv]
`timescale 1ns/1ps
module slmi_lane_map_invert_test;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  slmi_pkg::slmi_req_s reg_req = '0;
  slmi_pkg::slmi_data_t reg_rdata, logical_lane = 8'h00, serial_output_lane, rx_q;
  logic reg_rvalid;
  logic [23:0] lane_sel;
  int bad_count = 0;
  int n_checks = 0;
  always #5 core_clk = ~core_clk;
  slmi_lane_map_invert dut (.core_clk, .reset, .reg_req, .reg_rdata, .reg_rvalid,
    .logical_lane, .serial_output_lane, .lane_sel);
  slmi_lane_rx rx (.core_clk, .serial_output_lane, .rx_q);
  task automatic chk(input slmi_pkg::slmi_data_t got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // a read compares its answer against d
  task automatic acc(input logic w, input slmi_pkg::slmi_addr_t a, input slmi_pkg::slmi_data_t d);
    @(posedge core_clk) #1 reg_req = '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge core_clk) #1 reg_req = '0;
    chk(8'(reg_rvalid), 8'(!w));
    if (!w) chk(reg_rdata, d);
  endtask : acc
  task automatic lane_chk(input slmi_pkg::slmi_data_t i, m, e);
    @(posedge core_clk) #1 logical_lane = i;
    repeat (2) @(posedge core_clk);
    #1 chk(rx_q & m, e);
  endtask : lane_chk
  task automatic test_reset;
    acc(1'b0, 15'h05B2, 8'h10);
    acc(1'b0, 15'h05B3, 8'h32);
    acc(1'b0, 15'h05B5, 8'h54);
    acc(1'b0, 15'h05B6, 8'h76);
    acc(1'b0, 15'h05BF, 8'h00);
    acc(1'b0, 15'h05B4, 8'h00);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_map;
    acc(1'b1, 15'h05B6, 8'hFF);
    acc(1'b0, 15'h05B6, 8'h77);
    for (int v = 0; v < 8; v++) begin
      acc(1'b1, 15'h05B5, 8'h50 | 8'(v));
      lane_chk(8'h01 << v, 8'h10, 8'h10);
    end
    acc(1'b1, 15'h05B2, 8'h67);
    acc(1'b1, 15'h05B3, 8'h45);
    acc(1'b0, 15'h05B2, 8'h67);
    lane_chk(8'h80, 8'hFF, 8'hD1);
    acc(1'b1, 15'h05B2, 8'h10);
    acc(1'b1, 15'h05B3, 8'h32);
    $display("test_map done");
  endtask : test_map
  task automatic test_invert;
    acc(1'b1, 15'h05B5, 8'h54);
    acc(1'b1, 15'h05B6, 8'h01);
    acc(1'b1, 15'h05BF, 8'hA5);
    lane_chk(8'h03, 8'hFF, 8'h66);
    acc(1'b0, 15'h05BF, 8'hA5);
    reset = 1'b1;
    @(posedge core_clk) #1 reset = 1'b0;
    acc(1'b0, 15'h05BF, 8'h00);
    $display("test_invert done");
  endtask : test_invert
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (16) @(posedge core_clk);
    #1 reset = 1'b0;
    test_reset();
    test_map();
    test_invert();
    give_verdict();
  end
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
endmodule : slmi_lane_map_invert_test
